// >>> rtl/prot_pkg.sv
// constants shared by the excitation and underspeed protection block
`default_nettype none
package prot_pkg;
  // timing: figures in their own unit, cycle counts derived at 20 MHz
  localparam int CLK_PERIOD_NS    = 50;
  localparam int SAMPLE_PERIOD_US = 1000;
  localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int LED_SLOW_MS      = 500;
  localparam int LED_MED_MS       = 250;
  localparam int LED_FAST_MS      = 125;
  localparam logic [11:0] LED_SLOW_TICKS = 12'(LED_SLOW_MS * 1000 / SAMPLE_PERIOD_US);
  localparam logic [11:0] LED_MED_TICKS  = 12'(LED_MED_MS * 1000 / SAMPLE_PERIOD_US);
  localparam logic [11:0] LED_FAST_TICKS = 12'(LED_FAST_MS * 1000 / SAMPLE_PERIOD_US);
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_US_THR     = 6'h15;  // 21
  localparam logic [5:0] IDX_EXC_LIMIT  = 6'h16;  // 22
  localparam logic [5:0] IDX_VF_SLOPE   = 6'h17;  // 23
  localparam logic [5:0] IDX_OE_GAIN    = 6'h1c;  // 28
  localparam logic [5:0] IDX_DERATE     = 6'h1d;  // 29
  localparam logic [5:0] IDX_THR_SRC    = 6'h22;  // 34
  localparam logic [5:0] IDX_TEMP       = 6'h2d;  // 45
  localparam logic [5:0] IDX_APPLIED    = 6'h37;  // 55
  localparam logic [5:0] IDX_CTRL       = 6'h3c;
  localparam logic [5:0] IDX_STATUS     = 6'h3d;
  localparam logic [5:0] IDX_IRQ_STAT   = 6'h3e;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h3f;
  // control bits
  localparam int CTRL_AMP_EN = 0;
  localparam int CTRL_HZ_EN  = 1;
  localparam int CTRL_JMP_EN = 2;
  localparam int CTRL_MODE60 = 3;
  // event bits, same layout in status, irq status and mask
  localparam int EV_OVEREXC   = 0;
  localparam int EV_UNDERSPD  = 1;
  // reset values
  localparam logic [14:0] RST_EXC_LIMIT = 15'h7fff;
  localparam logic [14:0] RST_US_THR    = 15'h4000;  // 16384
  localparam logic [14:0] RST_VF_SLOPE  = 15'h2328;  // 9000
  localparam logic [14:0] RST_OE_GAIN   = 15'h0400;
  localparam logic [14:0] RST_DERATE    = 15'h2000;
  localparam logic [3:0]  RST_CTRL      = 4'h0;
  // frequencies in tenths of a hertz
  localparam logic [15:0] KNEE_50   = 16'h01ea;  // 49.0
  localparam logic [15:0] KNEE_60   = 16'h0237;  // 56.7
  localparam logic [15:0] US_LO_50  = 16'h0190;  // 40
  localparam logic [15:0] US_MID_50 = 16'h01c2;  // 45
  localparam logic [15:0] US_SPN_50 = 16'h0032;  // 5 Hz span
  localparam logic [15:0] US_LO_60  = 16'h01e0;  // 48
  localparam logic [15:0] US_MID_60 = 16'h021c;  // 54
  localparam logic [15:0] US_SPN_60 = 16'h003c;  // 6 Hz span
  localparam logic [14:0] P_MID     = 15'h4000;
  localparam logic [31:0] P_ROUND   = 32'h0000_2000;
  // arithmetic scaling
  localparam logic [15:0] VNOM         = 16'h7fff;
  localparam int          TEMP_SHIFT   = 8;
  localparam int          GAIN_SHIFT   = 12;
  localparam int          DERATE_SHIFT = 10;
  localparam int          VF_SHIFT     = 6;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage
`default_nettype wire

// >>> rtl/thermal_estimator.sv
// first-order rotor winding temperature estimate
`timescale 1ns/1ps
`default_nettype none
module thermal_estimator
  import prot_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic [14:0] exc_level,
  output logic      [14:0] temp_q
);
  logic signed [16:0] diff;

  assign diff = $signed({2'h0, exc_level}) - $signed({2'h0, temp_q});

  // closes a fixed fraction of the gap each tick, so the curve is exponential
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      temp_q <= 15'h0000;
    end else if (tick) begin
      temp_q <= temp_q + 15'(diff >>> TEMP_SHIFT);
    end
  end
endmodule // thermal_estimator
`default_nettype wire

// >>> rtl/limit_derate.sv
// lowers the excitation limit in proportion to frequency below the knee
`timescale 1ns/1ps
`default_nettype none
module limit_derate
  import prot_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [14:0] limit,
  input  wire logic [15:0] freq,
  input  wire logic [15:0] knee,
  input  wire logic [14:0] derate,
  output logic      [14:0] eff_q
);
  logic [15:0] deficit;
  logic [31:0] prod;
  logic [31:0] frac_full;
  logic [14:0] frac;
  logic [29:0] red;

  assign deficit   = (freq < knee) ? knee - freq : 16'h0000;
  assign prod      = 32'(deficit) * 32'(derate);
  assign frac_full = prod >> DERATE_SHIFT;
  assign frac      = (frac_full > 32'h0000_7fff) ? 15'h7fff : frac_full[14:0];
  assign red       = 30'(limit) * 30'(frac);

  // red never exceeds limit since frac stays below one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eff_q <= 15'h0000;
    end else begin
      eff_q <= limit - red[29:15];
    end
  end
endmodule // limit_derate
`default_nettype wire

// >>> rtl/exc_protect.sv
// excitation overcurrent and underspeed protection with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module exc_protect
  import prot_pkg::*;
#(
  parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [14:0] exc_level,
  input  wire logic [15:0] freq_meas,
  input  wire logic [14:0] current_limit_trimmer,
  input  wire logic [14:0] hz_trimmer,
  input  wire logic        line_sel_pin,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [15:0]      voltage_setpoint,
  output logic             alarm_overexc,
  output logic             alarm_underspeed,
  output logic             indicator_led,
  output logic             irq
);
  logic        aw_have_q, w_have_q, wr_commit, wr_ok;
  logic [5:0]  aw_idx_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [14:0] p_limit_q, p_thr_q, p_slope_q, p_gain_q, p_derate_q;
  logic [3:0]  ctrl_q;
  logic [1:0]  stat_q, mask_q, alarm_prev_q;
  logic [31:0] tick_cnt_q;
  logic        tick, sync1_q, sync2_q, mode60;
  logic [14:0] temp, applied_q, eff_limit, thr_src;
  logic [15:0] thr_q, knee, vf_def, integ_q;
  logic [31:0] vf_prod, vf_shift, rd_val;
  logic        over, alarm5_q, alarm6_q, rd_ok;
  logic signed [32:0] step, integ_sum;
  logic signed [17:0] sp_calc;
  logic [11:0] led_cnt_q, led_period;

  function automatic logic [14:0] merge15(logic [14:0] old_v,
                                          logic [31:0] d, logic [3:0] s);
    logic [15:0] r;
    r = {1'b0, old_v};
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r[14:0];
  endfunction

  function automatic logic [15:0] us_threshold(logic [14:0] p, logic m60);
    logic [15:0] base, span;
    logic [14:0] d;
    logic [31:0] sc;
    span = m60 ? US_SPN_60 : US_SPN_50;
    if (p < P_MID) begin
      base = m60 ? US_LO_60 : US_LO_50;
      d    = p;
    end else begin
      base = m60 ? US_MID_60 : US_MID_50;
      d    = p - P_MID;
    end
    sc = 32'(d) * 32'(span) + P_ROUND;
    return base + sc[29:14];
  endfunction

  // jumper pin is asynchronous to clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= line_sel_pin;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end
  assign tick = (tick_cnt_q == 32'(SAMPLE_CYCLES_P - 1));

  // AXI4-Lite write path: address and data taken in either order
  assign awready   = !aw_have_q && !bvalid;
  assign wready    = !w_have_q && !bvalid;
  assign wr_commit = aw_have_q && w_have_q && !bvalid;
  assign wr_ok     = (aw_idx_q == IDX_US_THR) || (aw_idx_q == IDX_EXC_LIMIT)
                  || (aw_idx_q == IDX_VF_SLOPE) || (aw_idx_q == IDX_OE_GAIN)
                  || (aw_idx_q == IDX_DERATE) || (aw_idx_q == IDX_CTRL)
                  || (aw_idx_q == IDX_IRQ_STAT) || (aw_idx_q == IDX_IRQ_MASK);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      aw_idx_q  <= 6'h00;
      w_have_q  <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= awaddr[7:2];
      end else if (wr_commit) begin
        aw_have_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end else if (wr_commit) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_commit) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p_limit_q  <= RST_EXC_LIMIT;
      p_thr_q    <= RST_US_THR;
      p_slope_q  <= RST_VF_SLOPE;
      p_gain_q   <= RST_OE_GAIN;
      p_derate_q <= RST_DERATE;
      mask_q     <= 2'h0;
    end else if (wr_commit) begin
      if (aw_idx_q == IDX_EXC_LIMIT) p_limit_q <= merge15(p_limit_q, wdata_q, wstrb_q);
      if (aw_idx_q == IDX_US_THR) p_thr_q <= merge15(p_thr_q, wdata_q, wstrb_q);
      if (aw_idx_q == IDX_VF_SLOPE) p_slope_q <= merge15(p_slope_q, wdata_q, wstrb_q);
      if (aw_idx_q == IDX_OE_GAIN) p_gain_q <= merge15(p_gain_q, wdata_q, wstrb_q);
      if (aw_idx_q == IDX_DERATE) p_derate_q <= merge15(p_derate_q, wdata_q, wstrb_q);
      if (aw_idx_q == IDX_IRQ_MASK && wstrb_q[0]) mask_q <= wdata_q[1:0];
    end
  end

  // a threshold or slope write hands the source back to the parameter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= RST_CTRL;
    end else if (wr_commit) begin
      if (aw_idx_q == IDX_CTRL && wstrb_q[0]) ctrl_q <= wdata_q[3:0];
      if (aw_idx_q == IDX_US_THR || aw_idx_q == IDX_VF_SLOPE) begin
        ctrl_q[CTRL_HZ_EN] <= 1'b0;
      end
    end
  end

  // sticky events; a new edge in the clearing cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_q       <= 2'h0;
      alarm_prev_q <= 2'h0;
    end else begin
      alarm_prev_q <= {alarm6_q, alarm5_q};
      stat_q <= ({alarm6_q, alarm5_q} & ~alarm_prev_q)
              | (stat_q & ~((wr_commit && aw_idx_q == IDX_IRQ_STAT
                             && wstrb_q[0]) ? wdata_q[1:0] : 2'h0));
    end
  end
  assign irq = |(stat_q & mask_q);

  // AXI4-Lite read path
  assign arready = !rvalid;
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    case (araddr[7:2])
      IDX_US_THR:    rd_val = 32'(p_thr_q);
      IDX_EXC_LIMIT: rd_val = 32'(p_limit_q);
      IDX_VF_SLOPE:  rd_val = 32'(p_slope_q);
      IDX_OE_GAIN:   rd_val = 32'(p_gain_q);
      IDX_DERATE:    rd_val = 32'(p_derate_q);
      IDX_THR_SRC:   rd_val = 32'(thr_src);
      IDX_TEMP:      rd_val = 32'(temp);
      IDX_APPLIED:   rd_val = 32'(applied_q);
      IDX_CTRL:      rd_val = 32'(ctrl_q);
      IDX_STATUS:    rd_val = 32'({alarm6_q, alarm5_q});
      IDX_IRQ_STAT:  rd_val = 32'(stat_q);
      IDX_IRQ_MASK:  rd_val = 32'(mask_q);
      default:       rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_val;
      rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  thermal_estimator u_est (
    .clk       (clk),
    .rst       (rst),
    .tick      (tick),
    .exc_level (exc_level),
    .temp_q    (temp)
  );

  assign mode60 = (ctrl_q[CTRL_JMP_EN] && sync2_q) || ctrl_q[CTRL_MODE60];
  assign knee   = mode60 ? KNEE_60 : KNEE_50;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      applied_q <= RST_EXC_LIMIT;
    end else begin
      applied_q <= ctrl_q[CTRL_AMP_EN] ? current_limit_trimmer : p_limit_q;
    end
  end

  limit_derate u_derate (
    .clk    (clk),
    .rst    (rst),
    .limit  (applied_q),
    .freq   (freq_meas),
    .knee   (knee),
    .derate (p_derate_q),
    .eff_q  (eff_limit)
  );

  // integral-only loop, gain shapes stability with a strong magnetic gain
  assign over      = temp > eff_limit;
  assign step      = ($signed({18'h0, temp}) - $signed({18'h0, eff_limit}))
                   * $signed({18'h0, p_gain_q}) >>> GAIN_SHIFT;
  assign integ_sum = $signed({17'h0, integ_q}) + step;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      integ_q <= 16'h0000;
    end else if (tick) begin
      if (integ_sum < 0) begin
        integ_q <= 16'h0000;
      end else if (integ_sum > $signed({17'h0, VNOM})) begin
        integ_q <= VNOM;
      end else begin
        integ_q <= integ_sum[15:0];
      end
    end
  end

  // alarm 5 lasts until the loop has fully unwound
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm5_q <= 1'b0;
      alarm6_q <= 1'b0;
    end else begin
      alarm5_q <= over || (integ_q != 16'h0000);
      alarm6_q <= freq_meas < thr_q;
    end
  end
  assign alarm_overexc    = alarm5_q;
  assign alarm_underspeed = alarm6_q;

  assign thr_src = ctrl_q[CTRL_HZ_EN] ? hz_trimmer : p_thr_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thr_q <= US_MID_50;
    end else begin
      thr_q <= us_threshold(thr_src, mode60);
    end
  end

  assign vf_def   = (freq_meas < thr_q) ? thr_q - freq_meas : 16'h0000;
  assign vf_prod  = 32'(vf_def) * 32'(p_slope_q);
  assign vf_shift = vf_prod >> VF_SHIFT;
  assign sp_calc  = $signed({2'h0, VNOM})
                  - $signed({2'h0, (vf_shift > 32'(VNOM)) ? VNOM : vf_shift[15:0]})
                  - $signed({2'h0, integ_q});

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      voltage_setpoint <= VNOM;
    end else begin
      voltage_setpoint <= (sp_calc < 0) ? 16'h0000 : sp_calc[15:0];
    end
  end

  // flash rate tells which alarm is up
  assign led_period = alarm5_q ? LED_FAST_TICKS
                    : (alarm6_q ? LED_MED_TICKS : LED_SLOW_TICKS);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_cnt_q     <= 12'h000;
      indicator_led <= 1'b0;
    end else if (tick) begin
      if (led_cnt_q >= led_period - 12'h001) begin
        led_cnt_q     <= 12'h000;
        indicator_led <= !indicator_led;
      end else begin
        led_cnt_q <= led_cnt_q + 12'h001;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_read_temp;
    arvalid && arready && araddr[7:2] == IDX_TEMP;
  endsequence
  sequence s_src_write;
    wr_commit && (aw_idx_q == IDX_US_THR || aw_idx_q == IDX_VF_SLOPE);
  endsequence
  sequence s_quiet;
    !alarm6_q && integ_q == 16'h0000 && vf_def == 16'h0000;
  endsequence

  chk_temp_readback: assert property (s_read_temp |=> rvalid && rdata == 32'($past(temp)))
    else $error("temperature readback mismatch");
  chk_alarm5_raise: assert property (over |=> alarm5_q)
    else $error("alarm 5 missing while limit exceeded");
  // a small excess can give a zero step, so only a positive step must grow
  chk_loop_grows: assert property (tick && over && step > 0 && integ_q < VNOM |=> integ_q > $past(integ_q))
    else $error("overexcitation loop did not back off");
  chk_alarm5_clear: assert property (!over && integ_q == 16'h0000 |=> !alarm5_q)
    else $error("alarm 5 held after condition ended");
  chk_alarm6_follow: assert property (freq_meas < thr_q |=> alarm6_q ##0 alarm_underspeed)
    else $error("alarm 6 missing below threshold");
  chk_trim_release: assert property (s_src_write |=> !ctrl_q[CTRL_HZ_EN])
    else $error("hz trimmer still enabled after write");
  chk_thr_midpoint: assert property (thr_src == P_MID |=> thr_q == ($past(mode60) ? US_MID_60 : US_MID_50))
    else $error("midpoint threshold wrong");
  chk_setpoint_nominal: assert property (s_quiet |=> voltage_setpoint == VNOM)
    else $error("setpoint off nominal without protection");
  chk_slope_zero: assert property (p_slope_q == 15'h0000 && integ_q == 16'h0000 |=> voltage_setpoint == VNOM)
    else $error("zero slope still reduced voltage");
  chk_status_sticky: assert property (stat_q[EV_OVEREXC] && !(wr_commit && aw_idx_q == IDX_IRQ_STAT) |=> stat_q[EV_OVEREXC])
    else $error("sticky status lost");
endmodule // exc_protect
`default_nettype wire

// >>> test/exc_protect_tb_top.sv
// self-checking bench for the excitation and underspeed protection block
`timescale 1ns/1ps
`default_nettype none
module exc_protect_tb_top;
  import prot_pkg::*;
  localparam int SC = 8;
  logic        clk, rst, line_sel_pin;
  logic [14:0] exc_level, current_limit_trimmer, hz_trimmer;
  logic [15:0] freq_meas, voltage_setpoint;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, d2;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, r;
  logic        alarm_overexc, alarm_underspeed, indicator_led, irq;
  int          n_mismatch, n_compared, k, t, p, th, mg, cnt, v, tv;
  int          pc[3] = '{0, 16384, 32767};
  int          sl[3] = '{18000, 0, 9000};

  exc_protect #(.SAMPLE_CYCLES_P(SC)) u_dut (
    .clk(clk), .rst(rst), .exc_level(exc_level), .freq_meas(freq_meas),
    .current_limit_trimmer(current_limit_trimmer), .hz_trimmer(hz_trimmer),
    .line_sel_pin(line_sel_pin), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .voltage_setpoint(voltage_setpoint), .alarm_overexc(alarm_overexc),
    .alarm_underspeed(alarm_underspeed), .indicator_led(indicator_led),
    .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // threshold in tenths of a hertz, rounded to nearest
  function automatic int thr(int pv, bit m60);
    int lo = m60 ? 480 : 400;
    int sp = m60 ? 60 : 50;
    if (pv < 16384)
      return lo + (pv * sp + 8192) / 16384;
    return lo + sp + ((pv - 16384) * sp + 8192) / 16384;
  endfunction

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic wr(input logic [5:0] i, input logic [31:0] dv,
                    output logic [1:0] rs);
    awaddr  <= {i, 2'h0};
    wdata   <= dv;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    rs = 2'h3;
    for (int j = 0; j < 64; j++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      // bready stays high; each write sets it again, so it never drops between writes
      if (bvalid === 1'b1) begin
        rs = bresp;
        break;
      end
    end
  endtask

  task automatic w(input logic [5:0] i, input logic [31:0] dv);
    logic [1:0] rs;
    wr(i, dv, rs);
    chk("bresp", 32'(RESP_OKAY), 32'(rs));
  endtask

  task automatic rd(input logic [5:0] i, output logic [31:0] dv,
                    output logic [1:0] rs);
    araddr  <= {i, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    rs = 2'h3;
    dv = 32'hffff_ffff;
    for (int j = 0; j < 64; j++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        dv = rdata;
        rs = rresp;
        break;
      end
    end
  endtask

  task automatic rc(input string n, input logic [5:0] i,
                    input logic [31:0] e);
    logic [31:0] dv;
    logic [1:0]  rs;
    rd(i, dv, rs);
    chk(n, e, dv);
  endtask

  // led toggles over 400 sample ticks
  task automatic led_cnt(output int c);
    logic lp;
    c = 0;
    lp = indicator_led;
    repeat (400 * SC) begin
      @(posedge clk);
      if (indicator_led !== lp) c++;
      lp = indicator_led;
    end
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // generous bound; the sequence needs well under half of it
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    finish_test;
  end

  initial begin
    rst = 1'b1;
    {exc_level, current_limit_trimmer, hz_trimmer, freq_meas} = '0;
    {awaddr, araddr, wdata, wstrb, line_sel_pin} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    n_mismatch = 0;
    n_compared = 0;
    freq_meas = 16'd600;
    v = $urandom(52);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc("thr param", IDX_US_THR, 32'(RST_US_THR));
    rc("slope", IDX_VF_SLOPE, 32'(RST_VF_SLOPE));
    rc("limit", IDX_EXC_LIMIT, 32'(RST_EXC_LIMIT));
    rc("ctrl", IDX_CTRL, 32'(RST_CTRL));
    rd(6'h00, d, r);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
    wr(IDX_TEMP, 32'h1, r);
    chk("read-only bresp", 32'(RESP_SLVERR), 32'(r));
    $display("test reset done");
    v = $urandom_range(32767, 1);
    tv = $urandom_range(32767, 1);
    w(IDX_EXC_LIMIT, v);
    rc("applied param", IDX_APPLIED, v);
    current_limit_trimmer <= 15'(tv);
    w(IDX_CTRL, 32'h1);
    rc("applied trimmer", IDX_APPLIED, tv);
    w(IDX_CTRL, 32'h0);
    $display("test limit source done");
    for (k = 0; k < 8; k++) begin
      p = k < 3 ? pc[k] : $urandom_range(32767);
      th = thr(p, k[0]);
      mg = k < 3 ? 1 : 2;
      w(IDX_US_THR, p);
      w(IDX_CTRL, {28'h0, k[0], 3'h0});
      freq_meas <= 16'(th - mg);
      repeat (4) @(posedge clk);
      chk("alarm6 below", 1, alarm_underspeed);
      rc("status", IDX_STATUS, 32'h2);
      freq_meas <= 16'(th - 1 + mg);
      repeat (4) @(posedge clk);
      chk("alarm6 above", 0, alarm_underspeed);
    end
    chk("irq masked", 0, irq);
    rc("irq status", IDX_IRQ_STAT, 32'h2);
    w(IDX_IRQ_STAT, 32'h3);
    rc("irq cleared", IDX_IRQ_STAT, 32'h0);
    $display("test underspeed threshold done");
    w(IDX_US_THR, 16384);
    w(IDX_CTRL, 32'h4);
    line_sel_pin <= 1'b1;
    freq_meas <= 16'd535;
    repeat (6) @(posedge clk);
    chk("jumper 60", 1, alarm_underspeed);
    line_sel_pin <= 1'b0;
    repeat (6) @(posedge clk);
    chk("jumper 50", 0, alarm_underspeed);
    hz_trimmer <= 15'd100;
    w(IDX_CTRL, 32'h2);
    rc("thr in use", IDX_THR_SRC, 32'd100);
    freq_meas <= 16'd401;
    repeat (4) @(posedge clk);
    chk("hz trimmer thr", 0, alarm_underspeed);
    w(IDX_US_THR, 16384);
    rc("trimmer off", IDX_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    chk("param thr", 1, alarm_underspeed);
    $display("test threshold sources done");
    freq_meas <= 16'd440;
    for (k = 0; k < 3; k++) begin
      w(IDX_VF_SLOPE, sl[k]);
      repeat (3 * SC) @(posedge clk);
      chk("vf setpoint", VNOM - 16'((10 * sl[k]) >> 6), voltage_setpoint);
    end
    freq_meas <= 16'd600;
    $display("test volts per hertz done");
    w(IDX_IRQ_MASK, 32'h1);
    w(IDX_EXC_LIMIT, 1000);
    exc_level <= 15'd20000;
    repeat (2 * SC) @(posedge clk);
    rd(IDX_TEMP, d, r);
    repeat (4 * SC) @(posedge clk);
    rd(IDX_TEMP, d2, r);
    chk("temp smooth rise", 1, d > 0 && d < d2 && d2 < 20000);
    for (t = 0; t < 4000 && alarm_overexc !== 1'b1; t++) @(posedge clk);
    chk("alarm5 set", 1, alarm_overexc);
    repeat (2) @(posedge clk);
    chk("irq raised", 1, irq);
    rc("applied during", IDX_APPLIED, 32'd1000);
    repeat (10 * SC) @(posedge clk);
    chk("setpoint lowered", 1, voltage_setpoint < VNOM);
    led_cnt(cnt);
    chk("led fast", 1, cnt >= 3 && cnt <= 4);
    w(IDX_IRQ_STAT, 32'h1);
    chk("irq w1c", 0, irq);
    exc_level <= 15'd0;
    w(IDX_EXC_LIMIT, 32767);
    for (t = 0; t < 20000 && alarm_overexc !== 1'b0; t++) @(posedge clk);
    chk("alarm5 clear", 0, alarm_overexc);
    for (t = 0; t < 20000 && voltage_setpoint !== VNOM; t++) @(posedge clk);
    chk("setpoint nominal", VNOM, voltage_setpoint);
    led_cnt(cnt);
    chk("led slow", 1, cnt <= 1);
    $display("test overexcitation done");
    finish_test;
  end
endmodule // exc_protect_tb_top
`default_nettype wire
